// ==== logic/bridge_output_command_handler.sv ====
// output command handler: register file, error clearing, banking, field outputs
// What this block does
// - error reset pulse clears error flags
// - same pulse clears error codes, lists, areas
// - power-up leaves every error cleared
// - detect command on-off starts address detection
// - single access: completion off, accessing on
// - batch read: completion off, accessing on
// - batch write: completion off, accessing on
// - bank select: off low half, on high
// - bank select taken only while not switching
// - banking covers the parameter slots, not the id lists
// - switch command updates banked words
// - host output bits forwarded to field slaves
// - address A owns word A/16, bit A%16
// - outputs reach all connected slaves
//
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "bridge_defs.svh"
module bridge_output_command_handler
  import bridge_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int SLOT_W = 48,
  parameter int SLOTS = 256,
  parameter int BANK_SW_CYCLES = `BANK_SW_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic irq,
  input wire logic fault_short,
  input wire logic fault_vdrop,
  input wire logic fault_disc,
  input wire logic error_event,
  input wire logic error_is_alarm,
  input wire logic error_on_output,
  input wire logic [7:0] error_point,
  input wire logic [15:0] error_code,
  input wire logic [15:0] error_id,
  input wire logic slot_wr_valid,
  input wire logic [7:0] slot_wr_index,
  input wire logic [SLOT_W-1:0] slot_wr_data,
  output logic addr_detect_start,
  output logic param_start,
  output access_kind_t param_kind,
  output logic [15:0] param_target,
  input wire logic param_done,
  input wire logic param_fail,
  output logic bank_shown,
  output logic [255:0] field_output_bits
);
  access_if acc ();

  // write channel
  logic aw_held, next_aw_held, w_held, next_w_held;
  logic [ADDR_W-1:0] wr_addr, next_wr_addr;
  logic [31:0] wr_data, next_wr_data;
  logic [3:0] wr_strb, next_wr_strb;
  logic bvalid_q, next_bvalid;
  logic [1:0] bresp_q, next_bresp;
  logic do_write;

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = (a < `OFS_REG_END) || (a[11:6] == `REGION_OUT) ||
      (a[11:8] == `REGION_POINT) || a[11];
  endfunction : mapped

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
      input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction : merge

  assign awready = !aw_held && !bvalid_q;
  assign wready = !w_held && !bvalid_q;
  assign do_write = aw_held && w_held && !bvalid_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;

  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    next_wr_strb = wr_strb;
    next_bvalid = bvalid_q;
    next_bresp = bresp_q;
    if (awvalid && awready) begin
      next_aw_held = 1'b1;
      next_wr_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_w_held = 1'b1;
      next_wr_data = wdata;
      next_wr_strb = wstrb;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = mapped(wr_addr) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bvalid_q && bready) begin
      next_bvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= '0;
      wr_data <= `WORD_ZERO;
      wr_strb <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      wr_addr <= next_wr_addr;
      wr_data <= next_wr_data;
      wr_strb <= next_wr_strb;
      bvalid_q <= next_bvalid;
      bresp_q <= next_bresp;
    end
  end

  // control state
  logic [`CMD_W-1:0] cmd, next_cmd, cmd_prev;
  logic [15:0] target, next_target;
  logic [15:0] out_words [`OUT_WORDS];
  logic [15:0] next_out_words [`OUT_WORDS];
  logic f_short, f_vdrop, f_disc, f_alarm, f_perr;
  logic next_f_short, next_f_vdrop, next_f_disc, next_f_alarm, next_f_perr;
  logic [15:0] last_code, next_last_code, last_id, next_last_id;
  logic [15:0] err_cnt, next_err_cnt, alm_cnt, next_alm_cnt;
  logic [255:0] point_map [`POINT_AREAS];
  logic [255:0] next_point_map [`POINT_AREAS];
  logic [`IRQ_W-1:0] irq_stat, next_irq_stat, irq_mask, next_irq_mask, ev;
  logic bank_sel, next_bank_sel, next_bank_shown, bank_busy, next_bank_busy;
  logic [3:0] bank_cnt, next_bank_cnt;
  logic next_detect;
  logic [`CMD_W-1:0] rise, fall;
  logic clr;
  logic [31:0] status;

  assign rise = cmd & ~cmd_prev;
  assign fall = cmd_prev & ~cmd;
  assign clr = fall[`CMD_ERR_RST];

  assign acc.start = !acc.accessing &&
    (rise[`CMD_PACC] || rise[`CMD_BRD] || rise[`CMD_BWR]);
  assign acc.kind = rise[`CMD_PACC] ? ACC_SINGLE :
    (rise[`CMD_BRD] ? ACC_BATCH_READ : ACC_BATCH_WRITE);

  always_comb begin
    status = `WORD_ZERO;
    status[`ST_SHORT] = f_short;
    status[`ST_VDROP] = f_vdrop;
    status[`ST_DISC] = f_disc;
    status[`ST_ACCESSING] = acc.accessing;
    status[`ST_ALARM] = f_alarm;
    status[`ST_COMPLETE] = acc.complete;
    status[`ST_PERR] = f_perr;
    status[`ST_BANK_BUSY] = bank_busy;
    status[`ST_BANK_SHOWN] = bank_shown;
  end

  always_comb begin
    next_cmd = cmd;
    next_target = target;
    next_out_words = out_words;
    next_irq_mask = irq_mask;
    next_point_map = point_map;
    next_last_code = last_code;
    next_last_id = last_id;
    next_err_cnt = err_cnt;
    next_alm_cnt = alm_cnt;
    if (do_write) begin
      if (wr_addr == `OFS_CMD && wr_strb[0]) begin
        next_cmd = wr_data[`CMD_W-1:0];
      end
      if (wr_addr == `OFS_TARGET) begin
        next_target = 16'(merge({16'h0000, target}, wr_data, wr_strb));
      end
      if (wr_addr == `OFS_IRQ_MASK && wr_strb[0]) begin
        next_irq_mask = wr_data[`IRQ_W-1:0];
      end
      if (wr_addr[11:6] == `REGION_OUT) begin
        next_out_words[wr_addr[5:2]] =
          16'(merge({16'h0000, out_words[wr_addr[5:2]]}, wr_data, wr_strb));
      end
    end
    next_f_short = (f_short && !clr) || fault_short;
    next_f_vdrop = (f_vdrop && !clr) || fault_vdrop;
    next_f_disc = (f_disc && !clr) || fault_disc;
    next_f_alarm = (f_alarm && !clr) || (error_event && error_is_alarm);
    next_f_perr = (f_perr && !clr) || acc.failed;
    if (clr) begin
      next_last_code = `HALF_ZERO;
      next_last_id = `HALF_ZERO;
      next_err_cnt = `HALF_ZERO;
      next_alm_cnt = `HALF_ZERO;
      for (int i = 0; i < `POINT_AREAS; i++) begin
        next_point_map[i] = '0;
      end
    end
    if (error_event) begin
      next_point_map[{error_is_alarm, error_on_output}][error_point] = 1'b1;
      if (error_is_alarm) begin
        if (next_alm_cnt < `LIST_MAX) next_alm_cnt = next_alm_cnt + 16'h0001;
      end else begin
        next_last_code = error_code;
        next_last_id = error_id;
        if (next_err_cnt < `LIST_MAX) next_err_cnt = next_err_cnt + 16'h0001;
      end
    end
    ev = '0;
    ev[`IRQ_SHORT] = next_f_short && !f_short;
    ev[`IRQ_VDROP] = next_f_vdrop && !f_vdrop;
    ev[`IRQ_DISC] = next_f_disc && !f_disc;
    ev[`IRQ_ALARM] = next_f_alarm && !f_alarm;
    ev[`IRQ_PERR] = next_f_perr && !f_perr;
    ev[`IRQ_DONE] = acc.finished;
    next_irq_stat = irq_stat;
    if (do_write && wr_addr == `OFS_IRQ_STAT && wr_strb[0]) begin
      next_irq_stat = irq_stat & ~wr_data[`IRQ_W-1:0];
    end
    next_irq_stat = next_irq_stat | ev;
    next_detect = fall[`CMD_ADDR_DET];
    next_bank_sel = bank_busy ? bank_sel : cmd[`CMD_BANK_SEL];
    next_bank_busy = bank_busy;
    next_bank_cnt = bank_cnt;
    next_bank_shown = bank_shown;
    if (!bank_busy && rise[`CMD_BANK_SW]) begin
      next_bank_busy = 1'b1;
      next_bank_cnt = 4'(BANK_SW_CYCLES - 1);
    end else if (bank_busy) begin
      if (bank_cnt == 4'h0) begin
        next_bank_busy = 1'b0;
        next_bank_shown = bank_sel;
      end else begin
        next_bank_cnt = bank_cnt - 4'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd <= '0;
      cmd_prev <= '0;
      target <= `HALF_ZERO;
      for (int i = 0; i < `OUT_WORDS; i++) out_words[i] <= `HALF_ZERO;
      {f_short, f_vdrop, f_disc, f_alarm, f_perr} <= 5'h00;
      last_code <= `HALF_ZERO;
      last_id <= `HALF_ZERO;
      err_cnt <= `HALF_ZERO;
      alm_cnt <= `HALF_ZERO;
      for (int i = 0; i < `POINT_AREAS; i++) point_map[i] <= '0;
      irq_stat <= '0;
      irq_mask <= '0;
      bank_sel <= 1'b0;
      bank_shown <= 1'b0;
      bank_busy <= 1'b0;
      bank_cnt <= 4'h0;
      addr_detect_start <= 1'b0;
    end else begin
      cmd <= next_cmd;
      cmd_prev <= cmd;
      target <= next_target;
      out_words <= next_out_words;
      {f_short, f_vdrop, f_disc, f_alarm, f_perr} <=
        {next_f_short, next_f_vdrop, next_f_disc, next_f_alarm, next_f_perr};
      last_code <= next_last_code;
      last_id <= next_last_id;
      err_cnt <= next_err_cnt;
      alm_cnt <= next_alm_cnt;
      point_map <= next_point_map;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      bank_sel <= next_bank_sel;
      bank_shown <= next_bank_shown;
      bank_busy <= next_bank_busy;
      bank_cnt <= next_bank_cnt;
      addr_detect_start <= next_detect;
    end
  end

  assign irq = |(irq_stat & irq_mask);
  assign param_target = target;

  // address A sits at word A/16, bit A%16
  for (genvar g = 0; g < `OUT_WORDS; g++) begin : g_out
    assign field_output_bits[g*16 +: 16] = out_words[g];
  end

  param_sequencer u_seq (
    .aclk(aclk),
    .aresetn(aresetn),
    .acc(acc.seq),
    .field_start(param_start),
    .field_kind(param_kind),
    .field_done(param_done),
    .field_fail(param_fail)
  );

  // read channel; the slot memory adds one cycle
  rd_state_t rstate, next_rstate;
  logic [ADDR_W-1:0] rd_addr, next_rd_addr;
  logic [31:0] rdata_q, next_rdata;
  logic [1:0] rresp_q, next_rresp;
  logic [SLOT_W-1:0] slot_q;
  logic [7:0] slot_rd_index;

  // bank picks half of the slots
  assign slot_rd_index = {bank_shown, rd_addr[10:4]};

  bank_memory #(.WIDTH(SLOT_W), .DEPTH(SLOTS), .AW(8)) u_slots (
    .clk(aclk),
    .wr_en(slot_wr_valid),
    .wr_addr(slot_wr_index),
    .wr_data(slot_wr_data),
    .rd_addr(slot_rd_index),
    .rd_data(slot_q)
  );

  assign arready = (rstate == RD_IDLE);
  assign rvalid = (rstate == RD_RESP);
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  always_comb begin
    next_rstate = rstate;
    next_rd_addr = rd_addr;
    next_rdata = rdata_q;
    next_rresp = rresp_q;
    case (rstate)
      RD_IDLE: begin
        if (arvalid) begin
          next_rd_addr = araddr;
          next_rstate = RD_FETCH;
        end
      end
      RD_FETCH: next_rstate = RD_LOAD;
      RD_LOAD: begin
        next_rstate = RD_RESP;
        next_rresp = mapped(rd_addr) ? `RESP_OKAY : `RESP_SLVERR;
        next_rdata = `WORD_ZERO;
        if (rd_addr[11]) begin
          if (rd_addr[3:2] != 2'h3) next_rdata[15:0] = slot_q[rd_addr[3:2]*16 +: 16];
        end else if (rd_addr[11:8] == `REGION_POINT) begin
          next_rdata[15:0] = point_map[rd_addr[7:6]][{rd_addr[5:2], 4'h0} +: 16];
        end else if (rd_addr[11:6] == `REGION_OUT) begin
          next_rdata[15:0] = out_words[rd_addr[5:2]];
        end else begin
          case (rd_addr)
            `OFS_CMD: next_rdata[`CMD_W-1:0] = cmd;
            `OFS_TARGET: next_rdata[15:0] = target;
            `OFS_STATUS: next_rdata = status;
            `OFS_LAST_CODE: next_rdata[15:0] = last_code;
            `OFS_LAST_ID: next_rdata[15:0] = last_id;
            `OFS_ERR_CNT: next_rdata[15:0] = err_cnt;
            `OFS_ALM_CNT: next_rdata[15:0] = alm_cnt;
            `OFS_IRQ_STAT: next_rdata[`IRQ_W-1:0] = irq_stat;
            `OFS_IRQ_MASK: next_rdata[`IRQ_W-1:0] = irq_mask;
            default: next_rdata = `WORD_ZERO;
          endcase
        end
      end
      RD_RESP: begin
        if (rready) next_rstate = RD_IDLE;
      end
      default: next_rstate = RD_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rstate <= RD_IDLE;
      rd_addr <= '0;
      rdata_q <= `WORD_ZERO;
      rresp_q <= `RESP_OKAY;
    end else begin
      rstate <= next_rstate;
      rd_addr <= next_rd_addr;
      rdata_q <= next_rdata;
      rresp_q <= next_rresp;
    end
  end
endmodule : bridge_output_command_handler

// ==== logic/bridge_defs.svh ====
// register offsets, field positions, reset values and counts of the command handler
`ifndef BRIDGE_DEFS_SVH
`define BRIDGE_DEFS_SVH

`define OFS_CMD 12'h000
`define OFS_TARGET 12'h004
`define OFS_STATUS 12'h008
`define OFS_LAST_CODE 12'h00C
`define OFS_LAST_ID 12'h010
`define OFS_ERR_CNT 12'h014
`define OFS_ALM_CNT 12'h018
`define OFS_IRQ_STAT 12'h01C
`define OFS_IRQ_MASK 12'h020
`define OFS_REG_END 12'h024
`define REGION_OUT 6'h01
`define REGION_POINT 4'h1

`define CMD_W 7
`define CMD_ERR_RST 0
`define CMD_ADDR_DET 1
`define CMD_PACC 2
`define CMD_BRD 3
`define CMD_BWR 4
`define CMD_BANK_SEL 5
`define CMD_BANK_SW 6

`define ST_SHORT 1
`define ST_VDROP 3
`define ST_DISC 4
`define ST_ACCESSING 11
`define ST_ALARM 16
`define ST_COMPLETE 17
`define ST_PERR 18
`define ST_BANK_BUSY 20
`define ST_BANK_SHOWN 21

`define IRQ_W 6
`define IRQ_SHORT 0
`define IRQ_VDROP 1
`define IRQ_DISC 2
`define IRQ_ALARM 3
`define IRQ_PERR 4
`define IRQ_DONE 5

`define OUT_WORDS 16
`define POINT_AREAS 4
`define LIST_MAX 16'h0100
`define BANK_SW_CYCLES 4
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define WORD_ZERO 32'h0000_0000
`define HALF_ZERO 16'h0000

`endif

// ==== logic/bridge_pkg.sv ====
// types shared by the command handler modules
package bridge_pkg;
  typedef enum logic [1:0] {
    ACC_SINGLE = 2'h0,
    ACC_BATCH_READ = 2'h1,
    ACC_BATCH_WRITE = 2'h2
  } access_kind_t;
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'h0,
    SEQ_LAUNCH = 2'h1,
    SEQ_WAIT = 2'h2
  } seq_state_t;
  typedef enum logic [1:0] {
    RD_IDLE = 2'h0,
    RD_FETCH = 2'h1,
    RD_LOAD = 2'h2,
    RD_RESP = 2'h3
  } rd_state_t;
endpackage : bridge_pkg

// ==== logic/access_if.sv ====
// handshake between the register file and the parameter access sequencer
`timescale 1ns/1ps
interface access_if;
  import bridge_pkg::*;
  logic start;
  access_kind_t kind;
  logic accessing;
  logic complete;
  logic finished;
  logic failed;
  modport host (output start, output kind, input accessing, input complete,
    input finished, input failed);
  modport seq (input start, input kind, output accessing, output complete,
    output finished, output failed);
endinterface : access_if

// ==== logic/bank_memory.sv ====
// slave parameter slot memory with registered read data
`timescale 1ns/1ps
module bank_memory #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule : bank_memory

// ==== logic/param_sequencer.sv ====
// runs one single or batch parameter access against the field side
`timescale 1ns/1ps
module param_sequencer
  import bridge_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  access_if.seq acc,
  output logic field_start,
  output access_kind_t field_kind,
  input wire logic field_done,
  input wire logic field_fail
);
  seq_state_t state, next_state;
  logic accessing, next_accessing;
  logic complete, next_complete;
  access_kind_t kind, next_kind;

  always_comb begin
    next_state = state;
    next_accessing = accessing;
    next_complete = complete;
    next_kind = kind;
    case (state)
      SEQ_IDLE: begin
        if (acc.start) begin
          next_accessing = 1'b1;
          next_complete = 1'b0;
          next_kind = acc.kind;
          next_state = SEQ_LAUNCH;
        end
      end
      SEQ_LAUNCH: next_state = SEQ_WAIT;
      SEQ_WAIT: begin
        if (field_done) begin
          next_accessing = 1'b0;
          next_complete = 1'b1;
          next_state = SEQ_IDLE;
        end
      end
      default: next_state = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= SEQ_IDLE;
      accessing <= 1'b0;
      complete <= 1'b0;
      kind <= ACC_SINGLE;
    end else begin
      state <= next_state;
      accessing <= next_accessing;
      complete <= next_complete;
      kind <= next_kind;
    end
  end

  assign field_start = (state == SEQ_LAUNCH);
  assign field_kind = kind;
  assign acc.accessing = accessing;
  assign acc.complete = complete;
  assign acc.finished = (state == SEQ_WAIT) && field_done;
  assign acc.failed = (state == SEQ_WAIT) && field_done && field_fail;
endmodule : param_sequencer

// ==== bench/bridge_cmd_checker.sv ====
// port-level assertions for the output command handler
`timescale 1ns/1ps
module bridge_cmd_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awready,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic irq,
  input wire logic addr_detect_start,
  input wire logic param_start,
  input wire logic [255:0] field_output_bits
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  chk_resp_single: assert property (bvalid && bready |=> !bvalid)
    else $error("write response repeated");
  chk_write_block: assert property (bvalid |-> !awready && !wready)
    else $error("write channel open during response");
  chk_read_lat: assert property (arvalid && arready |-> ##[1:4] rvalid)
    else $error("read answer late");
  chk_read_single: assert property (rvalid && rready |=> !rvalid)
    else $error("read answer repeated");
  chk_read_busy: assert property (rvalid |-> !arready)
    else $error("read address taken while answering");
  chk_detect_pulse: assert property (addr_detect_start |=> !addr_detect_start)
    else $error("detection start longer than one cycle");
  chk_start_pulse: assert property (param_start |=> !param_start)
    else $error("access start longer than one cycle");
  // outputs may only move as a register write completes
  chk_out_by_write: assert property ($changed(field_output_bits) |-> bvalid)
    else $error("output bits changed without a write");
  chk_reset_quiet: assert property ($rose(aresetn) |-> !irq && !bvalid && !rvalid && !param_start)
    else $error("outputs busy after reset");
  cover property (bvalid && bready);
  cover property (rvalid && rready);
  cover property (param_start);
  cover property ($rose(irq));
endmodule : bridge_cmd_checker
bind bridge_output_command_handler bridge_cmd_checker chk (.aclk(aclk), .aresetn(aresetn),
  .awready(awready), .wready(wready), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
  .arready(arready), .rvalid(rvalid), .rready(rready), .irq(irq),
  .addr_detect_start(addr_detect_start), .param_start(param_start),
  .field_output_bits(field_output_bits));

// ==== bench/field_responder.sv ====
// behavioural field side that answers each parameter access after a delay
`timescale 1ns/1ps
module field_responder (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic param_start,
  input wire logic [7:0] delay,
  input wire logic fail_next,
  output logic param_done,
  output logic param_fail
);
  int cnt = 0;
  always @(posedge aclk) begin
    param_done <= 1'b0;
    // fail only counts beside done, so show the wrong level otherwise
    param_fail <= ~fail_next;
    if (!aresetn) begin
      cnt <= 0;
    end else if (param_start) begin
      cnt <= int'(delay);
    end else if (cnt == 1) begin
      param_done <= 1'b1;
      param_fail <= fail_next;
      cnt <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule : field_responder

// ==== bench/tb_bridge_output_command_handler.sv ====
// self-checking bench for the output command handler
`timescale 1ns/1ps
`include "bridge_defs.svh"
module tb_bridge_output_command_handler;
  import bridge_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq, bank_shown;
  logic [1:0] bresp, rresp;
  logic fault_short = 1'b0, fault_vdrop = 1'b0, fault_disc = 1'b0, error_event = 1'b0;
  logic error_is_alarm = 1'b0, error_on_output = 1'b0, slot_wr_valid = 1'b0, fail_next = 1'b0;
  logic [7:0] error_point = 8'h00, slot_wr_index = 8'h00, delay = 8'h28;
  logic [15:0] error_code = 16'h0000, error_id = 16'h0000, param_target;
  logic [47:0] slot_wr_data = 48'h0000_0000_0000;
  logic addr_detect_start, param_start, param_done, param_fail;
  access_kind_t param_kind;
  logic [255:0] field_output_bits;
  logic [31:0] exp_r[$];
  logic [1:0] exp_b[$];
  logic [17:0] exp_k[$];
  int n_fail = 0;
  int compares = 0;
  int det_cnt = 0;

  always #20 aclk = ~aclk;

  bridge_output_command_handler dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .irq, .fault_short, .fault_vdrop, .fault_disc, .error_event,
    .error_is_alarm, .error_on_output, .error_point, .error_code, .error_id, .slot_wr_valid,
    .slot_wr_index, .slot_wr_data, .addr_detect_start, .param_start, .param_kind, .param_target,
    .param_done, .param_fail, .bank_shown, .field_output_bits);
  field_responder far_side (.aclk, .aresetn, .param_start, .delay, .fail_next, .param_done,
    .param_fail);

  task automatic check(input logic [255:0] seen, input logic [255:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test

  task automatic tick(inout int n);
    @(posedge aclk);
    n++;
    if (n > 200) begin
      n_fail++;
      end_of_test();
    end
  endtask : tick

  // bready and rready stay high, so a response is always taken at once
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    logic ad;
    logic wd;
    n = 0;
    ad = 1'b0;
    wd = 1'b0;
    exp_b.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && wd)) begin
      tick(n);
      if (awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do tick(n); while (!bvalid);
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a, input logic [31:0] e);
    int n;
    n = 0;
    exp_r.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    do tick(n); while (!arready);
    arvalid <= 1'b0;
    do tick(n); while (!rvalid);
  endtask : axi_rd

  always @(posedge aclk) begin
    if (bvalid && bready) check(bresp, exp_b.pop_front());
    if (rvalid && rready) check({rresp, rdata}, {`RESP_OKAY, exp_r.pop_front()});
    if (param_start) check({param_kind, param_target}, exp_k.pop_front());
    if (addr_detect_start) det_cnt <= det_cnt + 1;
  end

  initial begin
    logic [15:0] v;
    logic [15:0] w;
    int n;
    void'($urandom(31));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    bready <= 1'b1;
    rready <= 1'b1;
    axi_rd(`OFS_STATUS, 32'h0000_0000);
    axi_rd(`OFS_ERR_CNT, 32'h0000_0000);
    axi_wr(`OFS_REG_END, 32'h0000_0000, `RESP_SLVERR);
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      v = (i == 1) ? 16'hc000 : 16'($urandom);
      axi_wr(12'(12'h040 + i * 4), {16'h0000, v}, `RESP_OKAY);
      check(field_output_bits[i*16 +: 16], v);
    end
    axi_rd(12'h044, 32'h0000_c000);
    $display("test outputs done");
    axi_wr(`OFS_IRQ_MASK, 32'h0000_0001, `RESP_OKAY);
    fault_short <= 1'b1;
    fault_vdrop <= 1'b1;
    fault_disc <= 1'b1;
    error_event <= 1'b1;
    error_is_alarm <= 1'b1;
    error_on_output <= 1'b1;
    error_point <= 8'h23;
    error_code <= 16'h0a5a;
    error_id <= 16'($urandom);
    @(posedge aclk);
    fault_short <= 1'b0;
    fault_vdrop <= 1'b0;
    fault_disc <= 1'b0;
    error_is_alarm <= 1'b0;
    error_on_output <= 1'b0;
    error_code <= 16'h0c3c;
    @(posedge aclk);
    error_event <= 1'b0;
    @(posedge aclk);
    check(irq, 1'b1);
    axi_rd(`OFS_STATUS, 32'h0001_001a);
    axi_rd(`OFS_LAST_CODE, 32'h0000_0c3c);
    axi_rd(`OFS_ERR_CNT, 32'h0000_0001);
    axi_rd(12'h108, 32'h0000_0008);
    axi_rd(12'h1c8, 32'h0000_0008);
    axi_wr(`OFS_IRQ_STAT, 32'h0000_0001, `RESP_OKAY);
    check(irq, 1'b0);
    axi_wr(`OFS_IRQ_MASK, 32'h0000_0008, `RESP_OKAY);
    check(irq, 1'b1);
    axi_wr(`OFS_CMD, 32'h0000_0001, `RESP_OKAY);
    axi_rd(`OFS_STATUS, 32'h0001_001a);
    axi_wr(`OFS_CMD, 32'h0000_0000, `RESP_OKAY);
    axi_rd(`OFS_STATUS, 32'h0000_0000);
    axi_rd(`OFS_LAST_CODE, 32'h0000_0000);
    axi_rd(`OFS_ERR_CNT, 32'h0000_0000);
    axi_rd(`OFS_ALM_CNT, 32'h0000_0000);
    axi_rd(12'h108, 32'h0000_0000);
    axi_rd(12'h1c8, 32'h0000_0000);
    axi_wr(`OFS_IRQ_STAT, 32'h0000_003f, `RESP_OKAY);
    check(irq, 1'b0);
    $display("test error reset done");
    axi_wr(`OFS_CMD, 32'h0000_0002, `RESP_OKAY);
    repeat (3) @(posedge aclk);
    check(det_cnt, 0);
    axi_wr(`OFS_CMD, 32'h0000_0000, `RESP_OKAY);
    repeat (3) @(posedge aclk);
    check(det_cnt, 1);
    $display("test detection done");
    axi_wr(`OFS_IRQ_MASK, 32'h0000_0020, `RESP_OKAY);
    for (int k = 0; k < 3; k++) begin
      v = 16'($urandom);
      fail_next <= (k == 2);
      axi_wr(`OFS_TARGET, {16'h0000, v}, `RESP_OKAY);
      exp_k.push_back({2'(k), v});
      axi_wr(`OFS_CMD, 32'h0000_0004 << k, `RESP_OKAY);
      axi_rd(`OFS_STATUS, 32'h0000_0800);
      n = 0;
      while (!param_done) tick(n);
      repeat (2) @(posedge aclk);
      axi_rd(`OFS_STATUS, (k == 2) ? 32'h0006_0000 : 32'h0002_0000);
      axi_wr(`OFS_CMD, 32'h0000_0000, `RESP_OKAY);
    end
    check(irq, 1'b1);
    axi_wr(`OFS_IRQ_STAT, 32'h0000_003f, `RESP_OKAY);
    $display("test parameter access done");
    v = 16'($urandom);
    w = 16'($urandom);
    slot_wr_valid <= 1'b1;
    slot_wr_index <= 8'h05;
    slot_wr_data <= {16'h0000, 16'h0000, v};
    @(posedge aclk);
    slot_wr_index <= 8'h85;
    slot_wr_data <= {w, 16'h0000, w};
    @(posedge aclk);
    slot_wr_valid <= 1'b0;
    axi_rd(12'h850, {16'h0000, v});
    axi_wr(`OFS_CMD, 32'h0000_0020, `RESP_OKAY);
    axi_wr(`OFS_CMD, 32'h0000_0060, `RESP_OKAY);
    // select dropped while the switch is still running must be ignored
    axi_wr(`OFS_CMD, 32'h0000_0040, `RESP_OKAY);
    n = 0;
    while (!bank_shown) tick(n);
    axi_rd(12'h850, {16'h0000, w});
    axi_rd(12'h858, {16'h0000, w});
    axi_rd(`OFS_STATUS, 32'h0026_0000);
    axi_wr(`OFS_CMD, 32'h0000_0000, `RESP_OKAY);
    axi_wr(`OFS_CMD, 32'h0000_0040, `RESP_OKAY);
    while (bank_shown) tick(n);
    axi_rd(12'h850, {16'h0000, v});
    $display("test banking done");
    end_of_test();
  end
endmodule : tb_bridge_output_command_handler
